// ===== shared/ccj_consts.vh
/*
 * Constants for the chained configuration controller with JTAG override.
 * Assumes a 50 MHz system clock; included by bare name from design files.
 */
`ifndef CCJ_CONSTS_VH
`define CCJ_CONSTS_VH

// -----------------------------------------------------------------------------
// Scheme select encodings
// -----------------------------------------------------------------------------
`define CCJ_SCHEME_W        2
`define CCJ_SCHEME_AS       2'h0
`define CCJ_SCHEME_FAS      2'h1
`define CCJ_SCHEME_PS       2'h2
`define CCJ_SCHEME_JTAG_ONLY 2'h3

// -----------------------------------------------------------------------------
// State codes
// -----------------------------------------------------------------------------
`define CCJ_ST_W            3
`define CCJ_ST_IDLE         3'h0
`define CCJ_ST_LOAD         3'h1
`define CCJ_ST_JTAG         3'h2
`define CCJ_ST_WAIT_DONE    3'h3
`define CCJ_ST_INIT         3'h4
`define CCJ_ST_ERROR        3'h5

// -----------------------------------------------------------------------------
// Sizes and timing
// -----------------------------------------------------------------------------
`define CCJ_IMAGE_BITS      16'h0100
`define CCJ_CLK_DIV_HALF    4'h4

`endif

// ===== design/ccj_edge_sync.v
/*
 * Two flip-flop synchroniser with rise and fall detection after the second stage.
 * Assumes the input is asynchronous to clk_i.
 */
`default_nettype none

module ccj_edge_sync #(
   parameter RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire clk_i,
   input  wire srst_i,
   // Asynchronous input
   input  wire async_i,
   // Synchronised outputs
   output wire level_o,
   output wire rise_o,
   output wire fall_o
);

   reg meta_q;
   reg sync_q;
   reg prev_q;

   always @(posedge clk_i) begin
      if (srst_i) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
         prev_q <= RESET_VAL;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   assign rise_o  = sync_q & ~prev_q;
   assign fall_o  = ~sync_q & prev_q;

endmodule // ccj_edge_sync

`default_nettype wire

// ===== design/ccj_config_ctrl.v
/*
 * Configuration controller of a chained programmable device: open-drain status
 * and done handshake, serial load of the image, and a JTAG load path that wins
 * over every other scheme.
 * Assumes external pull-ups on the shared lines and that all pins are
 * asynchronous to clk_i; the link clocks are sampled, not used as clocks.
 */
`include "ccj_consts.vh"
`default_nettype none

module ccj_config_ctrl #(
   parameter [15:0] IMAGE_BITS = `CCJ_IMAGE_BITS
) (
   // Clock and reset
   input  wire       clk_i,
   input  wire       srst_i,
   // Chain and scheme pins
   input  wire       chip_enable_in_n_i,
   output wire       chain_enable_out_n_o,
   input  wire [1:0] scheme_select_pins_i,
   input  wire       decompress_en_i,
   // Open-drain status line
   input  wire       config_status_line_n_i,
   output wire       config_status_line_n_o,
   output wire       config_status_line_n_oe_n_o,
   // Open-drain done line
   input  wire       config_done_line_i,
   output wire       config_done_line_o,
   output wire       config_done_line_oe_n_o,
   // Serial configuration link
   input  wire       config_clock_in_i,
   output wire       config_clock_out_o,
   input  wire       config_data_i,
   // JTAG link
   input  wire       jtag_tck_i,
   input  wire       jtag_load_req_i,
   input  wire       jtag_tdi_i,
   // Status to the device core
   output wire       init_mode_o,
   output wire       jtag_active_o,
   output wire       bit_valid_o,
   output wire       bit_data_o,
   output wire       bit_decompress_o,
   output wire       load_error_o
);

   // --------------------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------------------
   wire ce_n_s;
   wire status_n_s;
   wire done_s;
   wire done_rise;
   wire config_clock_out_rise;
   wire tck_rise;
   wire jreq_s;
   wire jreq_rise;
   wire data_s;
   wire tdi_s;

   ccj_edge_sync #(.RESET_VAL(1'b1)) u_ce (
      .clk_i (clk_i), .srst_i (srst_i), .async_i (chip_enable_in_n_i),
      .level_o (ce_n_s), .rise_o (), .fall_o ());
   ccj_edge_sync #(.RESET_VAL(1'b1)) u_st (
      .clk_i (clk_i), .srst_i (srst_i), .async_i (config_status_line_n_i),
      .level_o (status_n_s), .rise_o (), .fall_o ());
   ccj_edge_sync #(.RESET_VAL(1'b0)) u_dn (
      .clk_i (clk_i), .srst_i (srst_i), .async_i (config_done_line_i),
      .level_o (done_s), .rise_o (done_rise), .fall_o ());
   ccj_edge_sync #(.RESET_VAL(1'b0)) u_dc (
      .clk_i (clk_i), .srst_i (srst_i), .async_i (config_clock_in_i),
      .level_o (), .rise_o (config_clock_out_rise), .fall_o ());
   ccj_edge_sync #(.RESET_VAL(1'b0)) u_tk (
      .clk_i (clk_i), .srst_i (srst_i), .async_i (jtag_tck_i),
      .level_o (), .rise_o (tck_rise), .fall_o ());
   ccj_edge_sync #(.RESET_VAL(1'b0)) u_jr (
      .clk_i (clk_i), .srst_i (srst_i), .async_i (jtag_load_req_i),
      .level_o (jreq_s), .rise_o (jreq_rise), .fall_o ());
   ccj_edge_sync #(.RESET_VAL(1'b0)) u_dt (
      .clk_i (clk_i), .srst_i (srst_i), .async_i (config_data_i),
      .level_o (data_s), .rise_o (), .fall_o ());
   ccj_edge_sync #(.RESET_VAL(1'b0)) u_ti (
      .clk_i (clk_i), .srst_i (srst_i), .async_i (jtag_tdi_i),
      .level_o (tdi_s), .rise_o (), .fall_o ());

   // The scheme straps are pins as well, so they take the same two-stage path.
   wire [1:0] scheme_s;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sel
         ccj_edge_sync #(.RESET_VAL(1'b0)) u_sel (
            .clk_i   (clk_i),
            .srst_i  (srst_i),
            .async_i (scheme_select_pins_i[gi]),
            .level_o (scheme_s[gi]),
            .rise_o  (),
            .fall_o  ());
      end
   endgenerate

   // --------------------------------------------------------------------------
   // Scheme decode
   // --------------------------------------------------------------------------
   function is_active_serial;
      input [1:0] sel;
      begin
         is_active_serial = (sel == `CCJ_SCHEME_AS) || (sel == `CCJ_SCHEME_FAS);
      end
   endfunction

   wire as_mode = is_active_serial(scheme_s);

   // --------------------------------------------------------------------------
   // Load sequencer
   // --------------------------------------------------------------------------
   reg [2:0]  state_q;
   reg [2:0]  state_d;
   reg [15:0] count_q;
   reg [15:0] count_d;
   reg        bit_valid_q;
   reg        bit_data_q;
   reg        bit_dec_q;
   reg        div_clk_q;
   reg [3:0]  div_cnt_q;

   wire [15:0] last_bit = IMAGE_BITS - 16'h0001;
   // In active serial schemes the source clock is our own divider.
   wire serial_edge = as_mode ? (div_cnt_q == 4'h0 && !div_clk_q) : config_clock_out_rise;
   wire take_serial = (state_q == `CCJ_ST_LOAD) && serial_edge;
   wire take_jtag   = (state_q == `CCJ_ST_JTAG) && tck_rise;
   // A new JTAG request preempts any scheme mid-load.
   wire jtag_start  = jreq_rise;

   always @* begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         `CCJ_ST_IDLE: begin
            if (jtag_start) begin
               state_d = `CCJ_ST_JTAG;
               count_d = 16'h0000;
            end else if (!ce_n_s && status_n_s &&
                         scheme_s != `CCJ_SCHEME_JTAG_ONLY) begin
               state_d = `CCJ_ST_LOAD;
               count_d = 16'h0000;
            end
         end
         `CCJ_ST_LOAD: begin
            if (jtag_start) begin
               state_d = `CCJ_ST_JTAG;
               count_d = 16'h0000;
            end else if (!status_n_s) begin
               state_d = `CCJ_ST_ERROR;
            end else if (take_serial) begin
               count_d = count_q + 16'h0001;
               if (count_q == last_bit) begin
                  state_d = `CCJ_ST_WAIT_DONE;
               end
            end
         end
         `CCJ_ST_JTAG: begin
            if (take_jtag) begin
               count_d = count_q + 16'h0001;
               if (count_q == last_bit) begin
                  state_d = `CCJ_ST_WAIT_DONE;
               end
            end else if (!jreq_s) begin
               state_d = `CCJ_ST_ERROR;
            end
         end
         `CCJ_ST_WAIT_DONE: begin
            if (jtag_start) begin
               state_d = `CCJ_ST_JTAG;
               count_d = 16'h0000;
            end else if (done_rise || done_s) begin
               state_d = `CCJ_ST_INIT;
            end
         end
         `CCJ_ST_INIT: begin
            if (jtag_start) begin
               state_d = `CCJ_ST_JTAG;
               count_d = 16'h0000;
            end
         end
         `CCJ_ST_ERROR: begin
            if (jtag_start) begin
               state_d = `CCJ_ST_JTAG;
               count_d = 16'h0000;
            end
         end
         default: begin
            state_d = `CCJ_ST_IDLE;
            count_d = 16'h0000;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         state_q     <= `CCJ_ST_IDLE;
         count_q     <= 16'h0000;
         bit_valid_q <= 1'b0;
         bit_data_q  <= 1'b0;
         bit_dec_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         count_q     <= count_d;
         bit_valid_q <= (take_serial && !jtag_start) || take_jtag;
         bit_data_q  <= take_jtag ? tdi_s : data_s;
         // Decompression only ever applies to serial-scheme data.
         // The flag follows the valid pulse, so an aborted bit never leaves it set.
         bit_dec_q   <= take_serial && !jtag_start && decompress_en_i;
      end
   end

   // --------------------------------------------------------------------------
   // Configuration clock divider
   // --------------------------------------------------------------------------
   // Runs only while an active serial load is in progress; JTAG stops it.
   wire div_run = as_mode && (state_q == `CCJ_ST_LOAD);

   always @(posedge clk_i) begin
      if (srst_i) begin
         div_cnt_q <= 4'h0;
         div_clk_q <= 1'b0;
      end else if (!div_run) begin
         div_cnt_q <= 4'h0;
         div_clk_q <= 1'b0;
      end else if (div_cnt_q == `CCJ_CLK_DIV_HALF - 4'h1) begin
         div_cnt_q <= 4'h0;
         div_clk_q <= ~div_clk_q;
      end else begin
         div_cnt_q <= div_cnt_q + 4'h1;
      end
   end

   // --------------------------------------------------------------------------
   // Pins
   // --------------------------------------------------------------------------
   wire loaded = (state_q == `CCJ_ST_WAIT_DONE) || (state_q == `CCJ_ST_INIT);

   // Open-drain: output is always low; enable low means driving.
   assign config_status_line_n_o      = 1'b0;
   assign config_status_line_n_oe_n_o = (state_q != `CCJ_ST_ERROR);
   assign config_done_line_o          = 1'b0;
   assign config_done_line_oe_n_o     = loaded;
   assign chain_enable_out_n_o        = ~loaded;
   assign config_clock_out_o          = div_clk_q;

   assign init_mode_o      = (state_q == `CCJ_ST_INIT);
   assign jtag_active_o    = (state_q == `CCJ_ST_JTAG);
   assign bit_valid_o      = bit_valid_q;
   assign bit_data_o       = bit_data_q;
   assign bit_decompress_o = bit_dec_q;
   assign load_error_o     = (state_q == `CCJ_ST_ERROR);

endmodule // ccj_config_ctrl

`default_nettype wire

// ===== tb/ccj_partner.sv
/* Far side of the controller: the next device on the shared lines and the
   JTAG download host. Assumes the bench sets hold_done and pull_status. */
`default_nettype none
module ccj_partner (
   // Clock
   input  wire logic clk_i,
   // Device open-drain enables
   input  wire logic done_oe_n_i,
   input  wire logic status_oe_n_i,
   // Link pins
   output var  logic ser_clk_o,
   output var  logic ser_data_o,
   output var  logic tck_o,
   output var  logic tdi_o,
   output var  logic req_o,
   output wire logic done_o,
   output wire logic status_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 4;
   logic hold_done = 1'b1;
   logic pull_status = 1'b0;
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b0;
      tck_o = 1'b0;
      tdi_o = 1'b1;
      req_o = 1'b0;
   end
   // Pull-ups make both lines a wired AND of every party.
   assign done_o = (!done_oe_n_i || hold_done) ? 1'b0 : 1'b1;
   assign status_n_o = (!status_oe_n_i || pull_status) ? 1'b0 : 1'b1;
   // Link clocks stand still outside a frame; data shows the inverse after it.
   task automatic send(input logic jt, input logic [15:0] pat, input int n);
      if (jt) tdi_o = pat[0];
      else ser_data_o = pat[0];
      for (int i = 0; i < n; i++) begin
         repeat (HALF) @(negedge clk_i);
         if (jt) tck_o = 1'b1;
         else ser_clk_o = 1'b1;
         repeat (HALF) @(negedge clk_i);
         if (jt) tck_o = 1'b0;
         else ser_clk_o = 1'b0;
         if (jt) tdi_o = (i + 1 < n) ? pat[i + 1] : ~pat[i];
         else ser_data_o = (i + 1 < n) ? pat[i + 1] : ~pat[i];
      end
   endtask
endmodule // ccj_partner
`default_nettype wire

// ===== tb/ccj_config_ctrl_properties.sv
/* Checker bound to the configuration controller ports.
   Assumes clk_i as its one clock and srst_i as its reset. */
`default_nettype none
module ccj_config_props (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Pins and core status
   input wire logic chip_enable_in_n_i,
   input wire logic chain_enable_out_n_o,
   input wire logic jtag_load_req_i,
   input wire logic config_done_line_i,
   input wire logic config_done_line_oe_n_o,
   input wire logic config_status_line_n_oe_n_o,
   input wire logic config_clock_out_o,
   input wire logic init_mode_o,
   input wire logic jtag_active_o,
   input wire logic bit_valid_o,
   input wire logic bit_decompress_o,
   input wire logic load_error_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   status_err_a: assert property (!config_status_line_n_oe_n_o |-> load_error_o)
      else $error("status pulled low outside error");
   chain_release_a: assert property ($fell(chain_enable_out_n_o)
      |-> config_done_line_oe_n_o)
      else $error("chain enable without done release");
   done_hold_a: assert property (bit_valid_o |-> $past(!config_done_line_oe_n_o))
      else $error("done released while loading");
   init_together_a: assert property (!chain_enable_out_n_o && config_done_line_i
      |-> ##[0:6] init_mode_o)
      else $error("no init after done high");
   jtag_prio_a: assert property ($rose(jtag_load_req_i) |-> ##[1:5] jtag_active_o)
      else $error("jtag request not taken");
   clk_quiet_a: assert property (jtag_active_o && $past(jtag_active_o)
      |-> !config_clock_out_o)
      else $error("config clock during jtag");
   no_decomp_a: assert property (jtag_active_o |-> !bit_decompress_o)
      else $error("decompress flag on jtag bit");
   load_gate_a: assert property (bit_valid_o && !$past(jtag_active_o)
      |-> !$past(chip_enable_in_n_i, 4))
      else $error("serial bit without chip enable");
endmodule // ccj_config_props
bind ccj_config_ctrl ccj_config_props props_u (.clk_i, .srst_i, .chip_enable_in_n_i,
   .chain_enable_out_n_o, .jtag_load_req_i, .config_done_line_i, .config_done_line_oe_n_o,
   .config_status_line_n_oe_n_o, .config_clock_out_o, .init_mode_o, .jtag_active_o,
   .bit_valid_o, .bit_decompress_o, .load_error_o);
`default_nettype wire

// ===== tb/chained_config_with_jtag_override_test.sv
/* Self-checking bench for the configuration controller.
   Assumes the partner model and the checker are compiled before it. */
`include "ccj_consts.vh"
`default_nettype none
module chained_config_with_jtag_override_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] PAT = 16'ha5c3;
   // Row: scheme, decompress request, JTAG path, expected decompress flag.
   localparam logic [4:0] ROWS [5] = '{{`CCJ_SCHEME_PS, 3'b101}, {`CCJ_SCHEME_PS, 3'b000},
      {`CCJ_SCHEME_AS, 3'b110}, {`CCJ_SCHEME_FAS, 3'b010}, {`CCJ_SCHEME_JTAG_ONLY, 3'b110}};
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ce_n = 1'b1;
   logic [1:0] scheme = `CCJ_SCHEME_PS;
   logic dec = 1'b0;
   logic [15:0] got = 16'h0000;
   logic dec_seen = 1'b0;
   logic clk_seen = 1'b0;
   int num_errors = 0;
   int n_checks = 0;
   int nbits = 0;
   int cyc = 0;
   wire logic ser_clk, ser_data, tck, tdi, req, done_w, status_w, chain_n, st_oe_n, dn_oe_n;
   wire logic clk_o, init, jact, bv, bd, bdec, lerr;
   wire logic st_o, dn_o;
   ccj_config_ctrl #(.IMAGE_BITS(16)) dut_u (.clk_i(clk_i), .srst_i(srst_i),
      .chip_enable_in_n_i(ce_n), .chain_enable_out_n_o(chain_n), .scheme_select_pins_i(scheme),
      .decompress_en_i(dec), .config_status_line_n_i(status_w), .config_status_line_n_o(st_o),
      .config_status_line_n_oe_n_o(st_oe_n), .config_done_line_i(done_w),
      .config_done_line_o(dn_o), .config_done_line_oe_n_o(dn_oe_n), .config_clock_in_i(ser_clk),
      .config_clock_out_o(clk_o), .config_data_i(ser_data), .jtag_tck_i(tck),
      .jtag_load_req_i(req), .jtag_tdi_i(tdi), .init_mode_o(init), .jtag_active_o(jact),
      .bit_valid_o(bv), .bit_data_o(bd), .bit_decompress_o(bdec), .load_error_o(lerr));
   ccj_partner p_u (.clk_i(clk_i), .done_oe_n_i(dn_oe_n), .status_oe_n_i(st_oe_n),
      .ser_clk_o(ser_clk), .ser_data_o(ser_data), .tck_o(tck), .tdi_o(tdi), .req_o(req),
      .done_o(done_w), .status_n_o(status_w));
   initial forever #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (bv === 1'b1) begin
         nbits <= nbits + 1;
         got <= {bd, got[15:1]};
         dec_seen <= dec_seen | bdec;
      end
      if (cyc == 8000) begin
         num_errors++;
         $display("ERROR %0t: timeout", $time);
         complete_run;
      end
   end
   task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
      n_checks++;
      if (got_v !== exp_v) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic do_reset;
      srst_i = 1'b1;
      ce_n = 1'b1;
      p_u.req_o = 1'b0;
      p_u.hold_done = 1'b1;
      repeat (4) @(negedge clk_i);
      srst_i = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic load(input logic jt, input logic [15:0] pat, input int n);
      repeat (6) @(negedge clk_i);
      nbits = 0;
      p_u.send(jt, pat, n);
      repeat (6) @(negedge clk_i);
   endtask
   initial begin
      @(negedge clk_i);
      for (int r = 0; r < 5; r++) begin
         do_reset;
         scheme = ROWS[r][4:3];
         dec = ROWS[r][2];
         ce_n = 1'b0;
         p_u.req_o = ROWS[r][1];
         dec_seen = 1'b0;
         load(ROWS[r][1], PAT, 16);
         chk(nbits[15:0], 16'h0010);
         chk(got, PAT);
         chk(dec_seen, ROWS[r][0]);
         chk({chain_n, dn_oe_n}, 16'h0001);
         repeat (8) @(negedge clk_i);
         chk(init, 1'b0);
         p_u.hold_done = 1'b0;
         for (int k = 0; k < 12 && init !== 1'b1; k++) @(negedge clk_i);
         chk(init, 1'b1);
      end
      scheme = `CCJ_SCHEME_PS;
      do_reset;
      chk({dn_oe_n, st_oe_n, chain_n, clk_o}, 16'h0006);
      load(1'b0, PAT, 16);
      chk(nbits[15:0], 16'h0000);
      ce_n = 1'b0;
      load(1'b0, PAT, 8);
      chk(nbits[15:0], 16'h0008);
      p_u.req_o = 1'b1;
      repeat (6) @(negedge clk_i);
      chk(jact, 1'b1);
      load(1'b1, ~PAT, 16);
      chk(nbits[15:0], 16'h0010);
      chk(got, ~PAT);
      chk(chain_n, 1'b0);
      do_reset;
      ce_n = 1'b0;
      load(1'b0, PAT, 4);
      p_u.pull_status = 1'b1;
      repeat (6) @(negedge clk_i);
      p_u.pull_status = 1'b0;
      repeat (2) @(negedge clk_i);
      chk({lerr, st_oe_n, status_w}, 16'h0004);
      p_u.req_o = 1'b1;
      repeat (6) @(negedge clk_i);
      chk(jact, 1'b1);
      chk({st_o, dn_o}, 16'h0000);
      // Active serial: the block clocks its own source, which holds its data at one.
      do_reset;
      scheme = `CCJ_SCHEME_AS;
      ce_n = 1'b0;
      p_u.ser_data_o = 1'b1;
      nbits = 0;
      for (int k = 0; k < 200 && chain_n !== 1'b0; k++) begin
         @(negedge clk_i);
         if (clk_o === 1'b1) clk_seen = 1'b1;
      end
      repeat (2) @(negedge clk_i);
      chk(nbits[15:0], 16'h0010);
      chk(got, 16'hffff);
      chk(chain_n, 1'b0);
      chk(clk_seen, 1'b1);
      do_reset;
      ce_n = 1'b0;
      repeat (20) @(negedge clk_i);
      p_u.req_o = 1'b1;
      repeat (6) @(negedge clk_i);
      chk({jact, clk_o}, 16'h0002);
      complete_run;
   end
endmodule // chained_config_with_jtag_override_test
`default_nettype wire
